//--- logic/arpwm_defs.svh
`ifndef ARPWM_DEFS_SVH
`define ARPWM_DEFS_SVH
// Register word indices; byte address is four times the index.
`define IDX_CTRL_STATUS  5'h00
`define IDX_COUNT_HIGH   5'h01
`define IDX_COUNT_LOW    5'h02
`define IDX_RELOAD_HIGH  5'h03
`define IDX_RELOAD_LOW   5'h04
`define IDX_OUT_ENABLE   5'h05
`define IDX_CHAN_CS0     5'h06
`define IDX_DUTY0_HIGH   5'h0A
`define IDX_CAPT_HIGH    5'h12
`define IDX_CAPT_LOW     5'h13
`define IDX_SHADOW_CTRL  5'h14
`define IDX_BREAK_CTRL   5'h15
// Control/status fields.
`define BIT_CAPT_FLAG    6
`define BIT_CAPT_IE      5
`define BIT_CLK_SEL_HI   4
`define BIT_CLK_SEL_LO   3
`define BIT_OVF_FLAG     2
`define BIT_OVF_IE       1
`define BIT_CMP_IE       0
// Break control fields.
`define BIT_BREAK_ACT    5
`define BIT_BREAK_PIN_EN 4
// Reset values.
`define RST_SHADOW_CTRL  8'h01
// Slow mode divides the input clock by this figure.
`define SLOW_DIVIDE      32
`endif

//--- logic/arpwm_pkg.sv
package arpwm_pkg;
  typedef enum logic [1:0] {
    CLK_OFF,
    CLK_LITE,
    CLK_CPU,
    CLK_FAST
  } clk_sel_t;
endpackage : arpwm_pkg

//--- logic/autoreload_pwm_timer.sv
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`include "arpwm_defs.svh"
// Functional notes
// - With cpu clock selected, slow mode runs the timer from its input clock divided by 32.
// - Halt stops timer; active-halt stops unless lite clock and overflow irq.
// - All irqs wake from wait; only lite-clock overflow leaves active-halt.
// - Compare and capture share one irq output; overflow has its own.
// - Each event raises a request only when its enable bit is set.
// - Capture flag set on capture, cleared by captured-byte read, unwritable.
// - Two-bit clock select: off, lite, cpu, fast; cleared by reset.
// - PWM and compare need not work on the lite timebase clock.
// - Overflow flag set at wrap from FFFh, cleared by status read.
// - Bit 1 enables overflow irq, bit 0 compare irq; reset clears.
// - Counter resets to zero, counts each tick, reloads reload value.
// - Output enables reset to zero; zero frees the pin to GPIO.
// - Channel bit 1 inverts that channel's PWM signal; reset clears.
// - Channel bit 0 set on counter equal duty, cleared by read.
// - Break-active set by low break pin or software; reset clears.
// - Break-pin enable gates the break pin; software read/write.
// - Active break forces outputs to the four-bit break pattern.
// - Duty value sets PWM duty and the compare value per channel.
// - Capture pin edge copies counter to capture register if flag clear.
// - Overflow drives enabled outputs high; duty match drives them low.
// - Break start resets counter, reload, duties, duty shadows, output enables.
// - Shadow-load bit set at reset; loads shadows at overflow then clears.
module autoreload_pwm_timer #(
  parameter int CHANNELS = 4,
  parameter int WIDTH    = 12
) (
  // System.
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Wishbone slave.
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [6:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  output logic                     ack_o,
  // Counter clock sources, as one-cycle ticks.
  input  wire logic                lite_tick_i,
  input  wire logic                fast_tick_i,
  // Power modes.
  input  wire logic                slow_mode_i,
  input  wire logic                halt_i,
  input  wire logic                active_halt_i,
  // Pins.
  input  wire logic                capture_input_pin_i,
  input  wire logic                break_n_i,
  output logic      [CHANNELS-1:0] pwm_o,
  output logic      [CHANNELS-1:0] pwm_drive_o,
  // Interrupts and wake-up.
  output logic                     ovf_irq_o,
  output logic                     cap_cmp_irq_o,
  output logic                     wake_o
);

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [WIDTH-1:0] CNT_MAX = '1;

  logic [WIDTH-1:0]    count_reg;
  logic [WIDTH-1:0]    reload_reg;
  logic [WIDTH-1:0]    capture_reg;
  logic [3:0]          count_hi_latch_reg;
  logic [1:0]          clk_sel_reg;
  logic                cap_flag_reg;
  logic                cap_ie_reg;
  logic                ovf_flag_reg;
  logic                ovf_ie_reg;
  logic                cmp_ie_reg;
  logic [CHANNELS-1:0] oe_reg;
  logic [CHANNELS-1:0] inv_reg;
  logic [CHANNELS-1:0] inv_shadow_reg;
  logic [CHANNELS-1:0] cmp_flag_reg;
  logic [CHANNELS-1:0] pwm_raw_reg;
  logic [WIDTH-1:0]    duty_reg   [CHANNELS];
  logic [WIDTH-1:0]    duty_shadow_reg [CHANNELS];
  logic                shadow_load_reg;
  logic                break_act_reg;
  logic                break_pin_en_reg;
  logic [3:0]          break_pat_reg;
  logic [4:0]          slow_div_reg;
  logic [2:0]          cap_sync_reg;
  logic [2:0]          brk_sync_reg;
  logic                cap_level_reg;
  logic                brk_level_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; every access is answered in the cycle after it is seen.
  wire        bus_req   = cyc_i & stb_i & ~ack_o;
  wire [4:0]  idx       = adr_i[6:2];
  wire        wr        = bus_req & we_i & sel_i[0];
  wire        rd        = bus_req & ~we_i;
  wire [7:0]  wd        = dat_i[7:0];
  wire        wr_ctrl   = wr & (idx == `IDX_CTRL_STATUS);
  wire        wr_rel_hi = wr & (idx == `IDX_RELOAD_HIGH);
  wire        wr_rel_lo = wr & (idx == `IDX_RELOAD_LOW);
  wire        wr_oe     = wr & (idx == `IDX_OUT_ENABLE);
  wire        wr_shadow = wr & (idx == `IDX_SHADOW_CTRL);
  wire        wr_break  = wr & (idx == `IDX_BREAK_CTRL);
  wire        rd_ctrl   = rd & (idx == `IDX_CTRL_STATUS);
  wire        rd_cnt_lo = rd & (idx == `IDX_COUNT_LOW);
  wire        rd_capt   = rd & ((idx == `IDX_CAPT_HIGH) |
                                (idx == `IDX_CAPT_LOW));

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: stage 0 is read only by stage 1.
  wire cap_stable = cap_sync_reg[1] == cap_sync_reg[2];
  wire brk_stable = brk_sync_reg[1] == brk_sync_reg[2];
  wire cap_edge   = cap_stable & (cap_sync_reg[2] != cap_level_reg);
  wire break_pin  = break_pin_en_reg & ~brk_level_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_sync_reg  <= 3'h0;
      brk_sync_reg  <= 3'h7;
      cap_level_reg <= 1'b0;
      brk_level_reg <= 1'b1;
    end else begin
      cap_sync_reg <= {cap_sync_reg[1:0], capture_input_pin_i};
      brk_sync_reg <= {brk_sync_reg[1:0], break_n_i};
      if (cap_stable) begin
        cap_level_reg <= cap_sync_reg[2];
      end
      if (brk_stable) begin
        brk_level_reg <= brk_sync_reg[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter tick selection and power modes.
  wire       sel_lite   = clk_sel_reg == arpwm_pkg::CLK_LITE;
  wire       slow_tick  = slow_div_reg == 5'(`SLOW_DIVIDE - 1);
  wire       cpu_tick   = slow_mode_i ? slow_tick : 1'b1;
  wire       ah_run     = sel_lite & ovf_ie_reg;
  wire       halted     = halt_i | (active_halt_i & ~ah_run);
  logic      src_tick;

  always_comb begin
    unique case (arpwm_pkg::clk_sel_t'(clk_sel_reg))
      arpwm_pkg::CLK_OFF:  src_tick = 1'b0;
      arpwm_pkg::CLK_LITE: src_tick = lite_tick_i;
      arpwm_pkg::CLK_CPU:  src_tick = cpu_tick;
      arpwm_pkg::CLK_FAST: src_tick = fast_tick_i;
    endcase
  end

  wire tick     = src_tick & ~halted;
  wire overflow = tick & (count_reg == CNT_MAX);
  wire break_go = (wr_break & wd[`BIT_BREAK_ACT]) | break_pin;
  wire break_start = break_go & ~break_act_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_div_reg <= 5'h00;
    end else begin
      slow_div_reg <= slow_div_reg + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, reload and global control.
  always_ff @(posedge clk_i) begin
    if (rst_i || break_start) begin
      count_reg  <= '0;
      reload_reg <= '0;
      oe_reg     <= '0;
    end else begin
      if (overflow) begin
        count_reg <= reload_reg;
      end else if (tick) begin
        count_reg <= count_reg + 1'b1;
      end
      if (wr_rel_hi) begin
        reload_reg[WIDTH-1:8] <= wd[3:0];
      end
      if (wr_rel_lo) begin
        reload_reg[7:0] <= wd;
      end
      if (wr_oe) begin
        oe_reg <= {wd[6], wd[4], wd[2], wd[0]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_sel_reg        <= 2'h0;
      cap_ie_reg         <= 1'b0;
      ovf_ie_reg         <= 1'b0;
      cmp_ie_reg         <= 1'b0;
      ovf_flag_reg       <= 1'b0;
      cap_flag_reg       <= 1'b0;
      capture_reg        <= '0;
      count_hi_latch_reg <= 4'h0;
      break_act_reg      <= 1'b0;
      break_pin_en_reg   <= 1'b0;
      break_pat_reg      <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        cap_ie_reg  <= wd[`BIT_CAPT_IE];
        clk_sel_reg <= wd[`BIT_CLK_SEL_HI:`BIT_CLK_SEL_LO];
        ovf_ie_reg  <= wd[`BIT_OVF_IE];
        cmp_ie_reg  <= wd[`BIT_CMP_IE];
      end
      // Set beats the read-clear so a wrap in the read cycle is kept.
      if (overflow) begin
        ovf_flag_reg <= 1'b1;
      end else if (rd_ctrl) begin
        ovf_flag_reg <= 1'b0;
      end
      if (cap_edge && !cap_flag_reg) begin
        cap_flag_reg <= 1'b1;
        capture_reg  <= count_reg;
      end else if (rd_capt) begin
        cap_flag_reg <= 1'b0;
      end
      if (rd_cnt_lo) begin
        count_hi_latch_reg <= count_reg[WIDTH-1:8];
      end
      if (break_pin) begin
        break_act_reg <= 1'b1;
      end else if (wr_break) begin
        break_act_reg <= wd[`BIT_BREAK_ACT];
      end
      if (wr_break) begin
        break_pin_en_reg <= wd[`BIT_BREAK_PIN_EN];
        break_pat_reg    <= wd[3:0];
      end
    end
  end

  // Shadow-load bit: a fresh write loses to the clear only at overflow.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shadow_load_reg <= 1'(`RST_SHADOW_CTRL);
    end else if (shadow_load_reg && overflow) begin
      shadow_load_reg <= 1'b0;
    end else if (wr_shadow) begin
      shadow_load_reg <= wd[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel duty, compare and waveform.
  logic [7:0] chan_rd [CHANNELS];

  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    wire [4:0] duty_hi_idx = 5'(`IDX_DUTY0_HIGH + 2 * c);
    wire       wr_cs   = wr & (idx == 5'(`IDX_CHAN_CS0 + c));
    wire       rd_cs   = rd & (idx == 5'(`IDX_CHAN_CS0 + c));
    wire       wr_d_hi = wr & (idx == duty_hi_idx);
    wire       wr_d_lo = wr & (idx == duty_hi_idx + 5'h01);
    // Lite clock gives no compare or PWM; a zero duty never compares.
    wire       match   = tick & ~sel_lite & (count_reg == duty_shadow_reg[c])
                       & (duty_shadow_reg[c] != '0);

    always_ff @(posedge clk_i) begin
      if (rst_i || break_start) begin
        duty_reg[c]        <= '0;
        duty_shadow_reg[c] <= '0;
      end else begin
        if (wr_d_hi) begin
          duty_reg[c][WIDTH-1:8] <= wd[3:0];
        end
        if (wr_d_lo) begin
          duty_reg[c][7:0] <= wd;
        end
        if (overflow && shadow_load_reg) begin
          duty_shadow_reg[c] <= duty_reg[c];
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        inv_reg[c]        <= 1'b0;
        inv_shadow_reg[c] <= 1'b0;
        cmp_flag_reg[c]   <= 1'b0;
        pwm_raw_reg[c]    <= 1'b0;
      end else begin
        if (wr_cs) begin
          inv_reg[c] <= wd[1];
        end
        if (overflow && shadow_load_reg) begin
          inv_shadow_reg[c] <= inv_reg[c];
        end
        if (match) begin
          cmp_flag_reg[c] <= 1'b1;
        end else if (rd_cs) begin
          cmp_flag_reg[c] <= 1'b0;
        end
        if (overflow && !sel_lite) begin
          pwm_raw_reg[c] <= 1'b1;
        end else if (match) begin
          pwm_raw_reg[c] <= 1'b0;
        end
      end
    end

    assign chan_rd[c] = {6'h00, inv_reg[c], cmp_flag_reg[c]};
    // Break pattern is applied after the inverter.
    assign pwm_o[c] = break_act_reg ? break_pat_reg[c] :
                      (pwm_raw_reg[c] ^ inv_shadow_reg[c]);
    // Low enable means the block drives; break keeps the pins driven.
    assign pwm_drive_o[c] = ~(oe_reg[c] | break_act_reg);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts and wake-up.
  wire cmp_req = cmp_ie_reg & (|cmp_flag_reg);
  wire cap_req = cap_ie_reg & cap_flag_reg;
  assign ovf_irq_o     = ovf_ie_reg & ovf_flag_reg;
  assign cap_cmp_irq_o = cmp_req | cap_req;
  // Halt never wakes; active-halt only on a lite-clock overflow.
  assign wake_o = halt_i ? 1'b0 :
                  active_halt_i ? (ovf_irq_o & sel_lite) :
                  (ovf_irq_o | cap_cmp_irq_o);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped words read zero, reserved bits read zero.
  logic [7:0] rd_mux;
  wire  [4:0] chan_off  = idx - `IDX_CHAN_CS0;
  wire  [4:0] duty_off  = idx - `IDX_DUTY0_HIGH;
  wire        is_chan   = (idx >= `IDX_CHAN_CS0) && (idx < `IDX_DUTY0_HIGH);
  wire        is_duty   = (idx >= `IDX_DUTY0_HIGH) && (idx < `IDX_CAPT_HIGH);
  wire [WIDTH-1:0] duty_sel = duty_reg[duty_off[2:1]];

  always_comb begin
    rd_mux = 8'h00;
    if (is_chan) begin
      rd_mux = chan_rd[chan_off[1:0]];
    end else if (is_duty) begin
      rd_mux = duty_off[0] ? duty_sel[7:0] : {4'h0, duty_sel[WIDTH-1:8]};
    end else begin
      unique case (idx)
        `IDX_CTRL_STATUS: rd_mux = {1'b0, cap_flag_reg, cap_ie_reg,
                                    clk_sel_reg, ovf_flag_reg,
                                    ovf_ie_reg, cmp_ie_reg};
        `IDX_COUNT_HIGH:  rd_mux = {4'h0, count_hi_latch_reg};
        `IDX_COUNT_LOW:   rd_mux = count_reg[7:0];
        `IDX_RELOAD_HIGH: rd_mux = {4'h0, reload_reg[WIDTH-1:8]};
        `IDX_RELOAD_LOW:  rd_mux = reload_reg[7:0];
        `IDX_OUT_ENABLE:  rd_mux = {1'b0, oe_reg[3], 1'b0, oe_reg[2],
                                    1'b0, oe_reg[1], 1'b0, oe_reg[0]};
        `IDX_CAPT_HIGH:   rd_mux = {4'h0, capture_reg[WIDTH-1:8]};
        `IDX_CAPT_LOW:    rd_mux = capture_reg[7:0];
        `IDX_SHADOW_CTRL: rd_mux = {7'h00, shadow_load_reg};
        `IDX_BREAK_CTRL:  rd_mux = {2'h0, break_act_reg, break_pin_en_reg,
                                    break_pat_reg};
        default:          rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      dat_o <= rd ? {24'h000000, rd_mux} : 32'h0000_0000;
    end
  end

endmodule : autoreload_pwm_timer

//--- testbench/arpwm_pin_model.sv
`timescale 1ns/10ps
module arpwm_pin_model (
  // Requests from the bench.
  input  wire logic clk_i,
  input  wire logic cap_toggle_i,
  input  wire logic brk_hold_i,
  // Pins into the timer.
  output logic      cap_pin_o,
  output logic      brk_n_o
);
  logic cap_reg = 1'b0;
  logic brk_reg = 1'b1;
  assign cap_pin_o = cap_reg;
  assign brk_n_o   = brk_reg;
  // Pins move just after an edge, as a real source would look to the sync.
  always @(posedge clk_i) begin
    if (cap_toggle_i) begin
      cap_reg <= !cap_reg;
    end
    brk_reg <= !brk_hold_i;
  end
endmodule : arpwm_pin_model

//--- testbench/arpwm_monitor.sv
`timescale 1ns/10ps
module arpwm_monitor #(
  parameter int CHANNELS = 4
) (
  // System and bus.
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                cyc_i,
  input wire logic                stb_i,
  input wire logic                we_i,
  input wire logic [6:0]          adr_i,
  input wire logic [31:0]         dat_o,
  input wire logic                ack_o,
  // Power and pins.
  input wire logic                halt_i,
  input wire logic                active_halt_i,
  input wire logic [CHANNELS-1:0] pwm_o,
  input wire logic [CHANNELS-1:0] pwm_drive_o,
  // Interrupts.
  input wire logic                ovf_irq_o,
  input wire logic                cap_cmp_irq_o,
  input wire logic                wake_o
);
  wire       rd_take = cyc_i && stb_i && !we_i && !ack_o;
  wire [4:0] idx     = adr_i[6:2];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held past one cycle");
  ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack not given in the next cycle");
  upper_zero_a: assert property (
    ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  ovf_irq_a: assert property (
    rd_take && idx == 5'h00 |=>
      (dat_o[2] && dat_o[1]) == $past(ovf_irq_o))
    else $error("overflow request differs from flag and enable");
  capcmp_irq_a: assert property (
    rd_take && idx == 5'h00 ##1 (dat_o[6] && dat_o[5])
      |-> $past(cap_cmp_irq_o))
    else $error("capture request missing on shared output");
  break_force_a: assert property (
    rd_take && idx == 5'h15 ##1 dat_o[5] |-> $past(pwm_drive_o) == '0
      && $past(pwm_o) == dat_o[CHANNELS-1:0])
    else $error("break pattern not forced on pins");
  halt_wake_a: assert property (
    (halt_i && !active_halt_i) [*3] |-> !wake_o)
    else $error("wake request raised in halt");
  reset_release_a: assert property (
    $fell(rst_i) |-> pwm_drive_o == '1 && !ack_o && !ovf_irq_o)
    else $error("pins or flags not released after reset");
endmodule : arpwm_monitor

bind autoreload_pwm_timer arpwm_monitor #(.CHANNELS(CHANNELS))
  arpwm_monitor_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .dat_o, .ack_o, .halt_i, .active_halt_i, .pwm_o, .pwm_drive_o,
  .ovf_irq_o, .cap_cmp_irq_o, .wake_o);

//--- testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam int LIMIT = 30000;
  logic        clk_i       = 1'b0;
  logic        rst_i       = 1'b1;
  logic        cyc_i       = 1'b0;
  logic        stb_i       = 1'b0;
  logic        we_i        = 1'b0;
  logic [6:0]  adr_i       = 7'h00;
  logic [31:0] dat_i       = 32'h00000000;
  logic        slow_mode_i = 1'b0;
  logic        halt_i      = 1'b0;
  logic        active_halt = 1'b0;
  logic        cap_toggle  = 1'b0;
  logic        brk_hold    = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [3:0]  pwm_o;
  logic [3:0]  pwm_drive_o;
  logic        ovf_irq_o;
  logic        cap_cmp_irq_o;
  logic        wake_o;
  logic        cap_pin;
  logic        brk_n;
  logic [7:0]  d;
  logic [11:0] cnt;
  logic [11:0] prev;
  int          n_mismatch  = 0;
  int          n_compared  = 0;
  int          cycles      = 0;
  always #50 clk_i = !clk_i;
  autoreload_pwm_timer autoreload_pwm_timer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .lite_tick_i(cycles[2:0] == 3'h0),
    .fast_tick_i(1'b0), .slow_mode_i(slow_mode_i), .halt_i(halt_i),
    .active_halt_i(active_halt), .capture_input_pin_i(cap_pin),
    .break_n_i(brk_n), .pwm_o(pwm_o),
    .pwm_drive_o(pwm_drive_o), .ovf_irq_o(ovf_irq_o),
    .cap_cmp_irq_o(cap_cmp_irq_o), .wake_o(wake_o));
  arpwm_pin_model arpwm_pin_model_inst (.clk_i(clk_i),
    .cap_toggle_i(cap_toggle), .brk_hold_i(brk_hold),
    .cap_pin_o(cap_pin), .brk_n_o(brk_n));
  ////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic cmp(input string what, input logic [11:0] e,
                     input logic [11:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : cmp
  // The request is held until ack is sampled; the bench timeout bounds it.
  task automatic wb(input logic w, input logic [4:0] i,
                    input logic [7:0] v, output logic [7:0] r);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {i, 2'b00};
    dat_i <= {24'h000000, v};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [4:0] i, input logic [7:0] v);
    wb(1'b1, i, v, d);
  endtask : wr
  task automatic chk(input logic [4:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00, d);
    cmp("register", {4'h0, e}, {4'h0, d});
  endtask : chk
  task automatic rd_count;
    wb(1'b0, 5'h02, 8'h00, d);
    cnt[7:0] = d;
    wb(1'b0, 5'h01, 8'h00, d);
    cnt[11:8] = d[3:0];
  endtask : rd_count
  task automatic pulse_cap;
    cap_toggle <= 1'b1;
    @(posedge clk_i);
    cap_toggle <= 1'b0;
  endtask : pulse_cap
  // Width of one level of channel 0; one count of slack for match timing.
  task automatic width(input logic lvl);
    int n;
    n = 0;
    while (pwm_o[0] === lvl) @(posedge clk_i);
    while (pwm_o[0] !== lvl) @(posedge clk_i);
    while (pwm_o[0] === lvl) begin
      @(posedge clk_i);
      n++;
    end
    cmp("pwm width", 12'h001, {11'h000, n >= 1023 && n <= 1025});
  endtask : width
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 23; i++) begin
      chk(i[4:0], (i == 20) ? 8'h01 : 8'h00);
    end
    wr(5'h00, 8'hFF);
    chk(5'h00, 8'h3B);
    wr(5'h03, 8'hFF);
    chk(5'h03, 8'h0F);
    wr(5'h03, 8'h08);
    wr(5'h00, 8'h12);
    while (ovf_irq_o !== 1'b1) @(posedge clk_i);
    cmp("wake", 12'h001, {11'h000, wake_o});
    chk(5'h00, 8'h16);
    chk(5'h00, 8'h12);
    wr(5'h00, 8'h22);
    rd_count();
    cmp("count range", 12'h001, {11'h000, cnt >= 12'h800});
    pulse_cap();
    while (cap_cmp_irq_o !== 1'b1) @(posedge clk_i);
    chk(5'h00, 8'h62);
    wr(5'h00, 8'h32);
    pulse_cap();
    repeat (8) @(posedge clk_i);
    wr(5'h00, 8'h20);
    chk(5'h13, cnt[7:0]);
    chk(5'h12, {4'h0, cnt[11:8]});
    wb(1'b0, 5'h00, 8'h00, d);
    cmp("capture flag", 12'h000, {11'h000, d[6]});
    cmp("shared request", 12'h000, {11'h000, cap_cmp_irq_o});
    wr(5'h0A, 8'h0C);
    wr(5'h05, 8'h01);
    cmp("drive", 12'h00E, {8'h00, pwm_drive_o});
    wr(5'h14, 8'h01);
    wr(5'h00, 8'h11);
    width(1'b1);
    cmp("shared request", 12'h001, {11'h000, cap_cmp_irq_o});
    chk(5'h06, 8'h01);
    chk(5'h06, 8'h00);
    wr(5'h06, 8'h02);
    wr(5'h14, 8'h01);
    do wb(1'b0, 5'h14, 8'h00, d); while (d[0] !== 1'b0);
    width(1'b0);
    brk_hold <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(5'h15, 8'h00);
    wr(5'h15, 8'h1A);
    while (pwm_drive_o !== 4'h0) @(posedge clk_i);
    cmp("pattern", 12'h00A, {8'h00, pwm_o});
    chk(5'h15, 8'h3A);
    chk(5'h03, 8'h00);
    chk(5'h0A, 8'h00);
    chk(5'h05, 8'h00);
    brk_hold <= 1'b0;
    do begin
      wr(5'h15, 8'h00);
      wb(1'b0, 5'h15, 8'h00, d);
    end while (d[5] !== 1'b0);
    cmp("drive", 12'h00F, {8'h00, pwm_drive_o});
    wr(5'h15, 8'h25);
    cmp("pattern", 12'h005, {8'h00, pwm_o});
    wr(5'h15, 8'h00);
    halt_i <= 1'b1;
    rd_count();
    prev = cnt;
    rd_count();
    cmp("halted count", prev, cnt);
    halt_i <= 1'b0;
    active_halt <= 1'b1;
    rd_count();
    prev = cnt;
    rd_count();
    cmp("active-halt count", prev, cnt);
    cmp("wake", 12'h000, {11'h000, wake_o});
    wr(5'h00, 8'h0A);
    rd_count();
    prev = cnt;
    repeat (64) @(posedge clk_i);
    rd_count();
    prev = cnt - prev;
    cmp("lite ticks", 12'h001, {11'h000, prev inside {12'h008, 12'h009}});
    active_halt <= 1'b0;
    wr(5'h00, 8'h10);
    slow_mode_i <= 1'b1;
    rd_count();
    prev = cnt;
    repeat (64) @(posedge clk_i);
    rd_count();
    prev = cnt - prev;
    cmp("slow ticks", 12'h001, {11'h000, prev inside {12'h002, 12'h003}});
    conclude();
  end
endmodule : testbench
